// *** pmg_top.v ***
// Pulse modulation generator: registers, sequencer and output routing
`timescale 1ns/1ps
`include "pmg_defs.vh"
module pmg_top (
    // Clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // External pulse and trigger inputs
    input wire ext_pulse_in,
    input wire ext_trig_in,
    // Modulator side
    output reg rf_gate_out,
    output reg signal_valid_out,
    output reg slow_edge_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DELAY = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_LOAD = 3'h3;
    localparam ST_HIGH = 3'h4;
    localparam ST_LOW = 3'h5;

    // Clamp a tick count into [lo, hi]
    function [35:0] pmg_clamp;
        input [35:0] val;
        input [35:0] lo;
        input [35:0] hi;
        begin
            if (val < lo)
                pmg_clamp = lo;
            else if (val > hi)
                pmg_clamp = hi;
            else
                pmg_clamp = val;
        end
    endfunction

    // One clock eats several ticks; true when a count runs out now
    function pmg_expired;
        input [35:0] remain;
        begin
            pmg_expired = (remain <= `PMG_TICKS_PER_CLK);
        end
    endfunction

    reg enable_q;
    reg [1:0] mode_q;
    reg dbl_legacy_q;
    reg src_ext_q;
    reg slow_edge_q;
    reg sync_out_q;
    reg invert_q;
    reg [2:0] trig_mode_q;
    reg [3:0] time_hi_q;
    reg [35:0] period_q;
    reg [35:0] width_q;
    reg [35:0] delay_q;
    reg [35:0] dbl_delay_q;
    reg [35:0] dbl_width_q;
    reg [15:0] list_name_q;
    reg list_ok_q;
    reg error_q;
    reg sw_trig_q;
    reg trig_prev_q;
    reg [2:0] st_q;
    reg [35:0] pos_q;
    reg [35:0] seg_q;
    reg [15:0] rep_left_q;
    reg [10:0] idx_q;
    wire [35:0] wr_time;
    wire [35:0] wr_entry;
    wire wr_ctrl;
    wire list_clear;
    wire [19:0] mem_high;
    wire [19:0] mem_low;
    wire [15:0] mem_rep;
    wire [10:0] high_cnt;
    wire [10:0] low_cnt;
    wire [10:0] rep_cnt;
    wire [10:0] pair_cnt;
    wire [35:0] width_eff;
    wire dbl_on;
    wire train_on;
    wire one_shot;
    wire trig_rise;
    wire start_go;
    wire stop_now;
    wire first_on;
    wire second_on;
    wire pulse_int;
    wire mod_sig;
    ////////////////////////////////////////////////////////////////////
    // Write decode; a 36-bit time takes the high nibble staged first
    assign wr_time = {time_hi_q, reg_wdata_in};
    assign wr_entry = pmg_clamp(wr_time, 36'h0_0000_0000,
                                `PMG_ENTRY_MAX_TICKS);
    assign wr_ctrl = reg_wr_in && reg_addr_in == `PMG_REG_CTRL;
    // A new name starts an empty list; reselecting the same name keeps it
    assign list_clear = reg_wr_in && reg_addr_in == `PMG_REG_LIST_SEL &&
        (!list_ok_q || reg_wdata_in[15:0] != list_name_q);

    // Settings, times held as tick counts
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            enable_q <= 1'b0;
            mode_q <= `PMG_MODE_SINGLE;
            dbl_legacy_q <= 1'b0;
            src_ext_q <= 1'b0;
            slow_edge_q <= 1'b0;
            sync_out_q <= 1'b0;
            invert_q <= 1'b0;
            trig_mode_q <= `PMG_TRIG_AUTO;
            time_hi_q <= 4'h0;
            period_q <= `PMG_PERIOD_RST_NS / `PMG_TICK_NS;
            width_q <= `PMG_WIDTH_RST_NS / `PMG_TICK_NS;
            delay_q <= `PMG_DELAY_RST_NS / `PMG_TICK_NS;
            dbl_delay_q <= `PMG_DBL_DLY_RST_NS / `PMG_TICK_NS;
            dbl_width_q <= `PMG_DBL_WID_RST_NS / `PMG_TICK_NS;
            list_name_q <= 16'h0000;
            list_ok_q <= 1'b0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `PMG_REG_CTRL: begin
                    enable_q <= reg_wdata_in[`PMG_CTRL_ENABLE];
                    mode_q <= reg_wdata_in[`PMG_CTRL_MODE_HI:
                                           `PMG_CTRL_MODE_LO];
                    dbl_legacy_q <= reg_wdata_in[`PMG_CTRL_DBL_LEGACY];
                    src_ext_q <= reg_wdata_in[`PMG_CTRL_SRC_EXT];
                    slow_edge_q <= reg_wdata_in[`PMG_CTRL_SLOW_EDGE];
                    sync_out_q <= reg_wdata_in[`PMG_CTRL_SYNC_OUT];
                    invert_q <= reg_wdata_in[`PMG_CTRL_INVERT];
                    trig_mode_q <= reg_wdata_in[`PMG_CTRL_TRIG_HI:
                                                `PMG_CTRL_TRIG_LO];
                end
                `PMG_REG_TIME_HI: time_hi_q <= reg_wdata_in[3:0];
                `PMG_REG_PERIOD_LO: period_q <= pmg_clamp(wr_time,
                    `PMG_MIN_TICKS, `PMG_MAX_TICKS);
                // Width moves in 10 ns steps, so the lowest tick bit drops
                `PMG_REG_WIDTH_LO: width_q <= pmg_clamp({wr_time[35:1],
                    1'b0}, `PMG_MIN_TICKS, `PMG_MAX_TICKS);
                `PMG_REG_DELAY_LO: delay_q <= pmg_clamp(wr_time,
                    36'h0_0000_0000, `PMG_MAX_TICKS);
                `PMG_REG_DBL_DLY_LO: dbl_delay_q <= pmg_clamp(wr_time,
                    36'h0_0000_0000, `PMG_MAX_TICKS);
                `PMG_REG_DBL_WID_LO: dbl_width_q <= pmg_clamp(wr_time,
                    36'h0_0000_0000, `PMG_MAX_TICKS);
                `PMG_REG_LIST_SEL: begin
                    list_name_q <= reg_wdata_in[15:0];
                    list_ok_q <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Error flag: hardware set wins over a write-one clear
    always @(posedge sys_clk_in) begin
        if (sys_rst_in)
            error_q <= 1'b0;
        else if (wr_ctrl && !list_ok_q && reg_wdata_in[`PMG_CTRL_MODE_HI:
                 `PMG_CTRL_MODE_LO] == `PMG_MODE_TRAIN)
            error_q <= 1'b1;
        else if (reg_wr_in && reg_addr_in == `PMG_REG_STATUS &&
                 reg_wdata_in[`PMG_STAT_ERROR])
            error_q <= 1'b0;
    end

    // Software trigger and external trigger edge
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            sw_trig_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            sw_trig_q <= reg_wr_in && reg_addr_in == `PMG_REG_CMD &&
                reg_wdata_in[`PMG_CMD_TRIGGER];
            trig_prev_q <= ext_trig_in;
        end
    end

    pmg_train_mem u_mem (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(list_clear),
        .wr_high_in(reg_wr_in && list_ok_q &&
                    reg_addr_in == `PMG_REG_HIGH_LIST),
        .wr_low_in(reg_wr_in && list_ok_q &&
                   reg_addr_in == `PMG_REG_LOW_LIST),
        .wr_rep_in(reg_wr_in && list_ok_q &&
                   reg_addr_in == `PMG_REG_REP_LIST),
        .time_in(wr_entry[19:0]),
        .rep_in(reg_wdata_in[15:0]),
        .index_in(idx_q),
        .high_out(mem_high),
        .low_out(mem_low),
        .rep_out(mem_rep),
        .high_cnt_out(high_cnt),
        .low_cnt_out(low_cnt),
        .rep_cnt_out(rep_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // Only complete pairs play; the shortest list sets the train length
    assign pair_cnt = (high_cnt < low_cnt) ?
        ((high_cnt < rep_cnt) ? high_cnt : rep_cnt) :
        ((low_cnt < rep_cnt) ? low_cnt : rep_cnt);
    // Width constrained at use so a later shorter period stays legal
    assign width_eff = (width_q + `PMG_GAP_TICKS > period_q) ?
        period_q - `PMG_GAP_TICKS : width_q;
    assign dbl_on = mode_q == `PMG_MODE_DOUBLE || dbl_legacy_q;
    assign train_on = mode_q == `PMG_MODE_TRAIN && !dbl_legacy_q;
    assign one_shot = trig_mode_q == `PMG_TRIG_ONCE ||
        trig_mode_q == `PMG_TRIG_EXT_ONCE;
    assign trig_rise = ext_trig_in && !trig_prev_q;
    assign start_go = (trig_mode_q == `PMG_TRIG_AUTO) ||
        (trig_mode_q == `PMG_TRIG_ONCE && sw_trig_q) ||
        ((trig_mode_q == `PMG_TRIG_EXT ||
          trig_mode_q == `PMG_TRIG_EXT_ONCE) && trig_rise) ||
        (trig_mode_q == `PMG_TRIG_EXT_GATE && ext_trig_in);
    assign stop_now = !enable_q || src_ext_q || (train_on && !list_ok_q) ||
        (trig_mode_q == `PMG_TRIG_EXT_GATE && !ext_trig_in);

    // Sequencer: several ticks per clock; the period end compares forward
    // so a period cut below the running position still wraps at once
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_q <= ST_IDLE;
            pos_q <= 36'h0_0000_0000;
            seg_q <= 36'h0_0000_0000;
            rep_left_q <= 16'h0000;
            idx_q <= 11'h000;
        end else if (stop_now) begin
            st_q <= ST_IDLE;
            pos_q <= 36'h0_0000_0000;
            idx_q <= 11'h000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    pos_q <= 36'h0_0000_0000;
                    idx_q <= 11'h000;
                    if (start_go) begin
                        seg_q <= delay_q;
                        if (trig_mode_q != `PMG_TRIG_AUTO && delay_q != 0)
                            st_q <= ST_DELAY;
                        else
                            st_q <= train_on ? ST_LOAD : ST_RUN;
                    end
                end
                ST_DELAY: begin
                    if (pmg_expired(seg_q))
                        st_q <= train_on ? ST_LOAD : ST_RUN;
                    else
                        seg_q <= seg_q - `PMG_TICKS_PER_CLK;
                end
                ST_RUN: begin
                    if (pos_q + `PMG_TICKS_PER_CLK >= period_q) begin
                        pos_q <= 36'h0_0000_0000;
                        if (one_shot)
                            st_q <= ST_IDLE;
                    end else begin
                        pos_q <= pos_q + `PMG_TICKS_PER_CLK;
                    end
                end
                ST_LOAD: begin
                    if (idx_q >= pair_cnt) begin
                        idx_q <= 11'h000;
                        if (one_shot || pair_cnt == 0)
                            st_q <= ST_IDLE;
                    end else if (mem_rep == 16'h0000) begin
                        idx_q <= idx_q + 11'h001;
                    end else begin
                        rep_left_q <= mem_rep;
                        seg_q <= (mem_high == 0) ? {16'h0000, mem_low} :
                            {16'h0000, mem_high};
                        st_q <= (mem_high == 0) ? ST_LOW : ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (pmg_expired(seg_q)) begin
                        seg_q <= {16'h0000, mem_low};
                        st_q <= ST_LOW;
                    end else begin
                        seg_q <= seg_q - `PMG_TICKS_PER_CLK;
                    end
                end
                ST_LOW: begin
                    if (!pmg_expired(seg_q)) begin
                        seg_q <= seg_q - `PMG_TICKS_PER_CLK;
                    end else if (rep_left_q == 16'h0001) begin
                        idx_q <= idx_q + 11'h001;
                        st_q <= ST_LOAD;
                    end else begin
                        rep_left_q <= rep_left_q - 16'h0001;
                        seg_q <= (mem_high == 0) ? {16'h0000, mem_low} :
                            {16'h0000, mem_high};
                        st_q <= (mem_high == 0) ? ST_LOW : ST_HIGH;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Internal pulse shape and source routing
    assign first_on = pos_q < width_eff;
    assign second_on = dbl_on && pos_q >= dbl_delay_q &&
        pos_q < dbl_delay_q + dbl_width_q;
    assign pulse_int = (st_q == ST_RUN && (first_on || second_on)) ||
        st_q == ST_HIGH;
    // External source: normal polarity gates RF with the pulse, inverted with the gap; the internal pulse is never inverted
    assign mod_sig = src_ext_q ? (ext_pulse_in ^ invert_q) :
        pulse_int;

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rf_gate_out <= 1'b0;
            signal_valid_out <= 1'b0;
            slow_edge_out <= 1'b0;
        end else begin
            rf_gate_out <= enable_q && mod_sig;
            signal_valid_out <= sync_out_q && enable_q && mod_sig;
            slow_edge_out <= slow_edge_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data one cycle after the strobe, zero otherwise
    always @(posedge sys_clk_in) begin
        if (sys_rst_in || !reg_rd_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            case (reg_addr_in)
                `PMG_REG_CTRL: reg_rdata_out <= {21'h00_0000, trig_mode_q,
                    invert_q, sync_out_q, slow_edge_q, src_ext_q,
                    dbl_legacy_q, mode_q, enable_q};
                `PMG_REG_LIST_SEL: reg_rdata_out <= {15'h0000, list_ok_q,
                    list_name_q};
                `PMG_REG_STATUS: reg_rdata_out <= {25'h000_0000, st_q,
                    width_q != width_eff, pulse_int, st_q != ST_IDLE,
                    error_q};
                `PMG_REG_PERIOD_LO: reg_rdata_out <= period_q[31:0];
                `PMG_REG_WIDTH_LO: reg_rdata_out <= width_q[31:0];
                `PMG_REG_DELAY_LO: reg_rdata_out <= delay_q[31:0];
                `PMG_REG_DBL_DLY_LO: reg_rdata_out <= dbl_delay_q[31:0];
                `PMG_REG_DBL_WID_LO: reg_rdata_out <= dbl_width_q[31:0];
                `PMG_REG_TIME_HI: reg_rdata_out <= {28'h000_0000,
                    time_hi_q};
                `PMG_REG_COUNTS: reg_rdata_out <= {5'h00, low_cnt, 5'h00,
                    high_cnt};
                `PMG_REG_REP_COUNT: reg_rdata_out <= {21'h00_0000,
                    rep_cnt};
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule // pmg_top

// *** pmg_defs.vh ***
// Constants of the pulse modulation generator: map, fields, resets, timing
`ifndef PMG_DEFS_VH
`define PMG_DEFS_VH

// Register byte offsets
`define PMG_REG_CTRL        8'h00
`define PMG_REG_CMD         8'h04
`define PMG_REG_LIST_SEL    8'h08
`define PMG_REG_STATUS      8'h0C
`define PMG_REG_PERIOD_LO   8'h10
`define PMG_REG_WIDTH_LO    8'h14
`define PMG_REG_DELAY_LO    8'h18
`define PMG_REG_DBL_DLY_LO  8'h1C
`define PMG_REG_DBL_WID_LO  8'h20
`define PMG_REG_TIME_HI     8'h24
`define PMG_REG_HIGH_LIST   8'h28
`define PMG_REG_LOW_LIST    8'h2C
`define PMG_REG_REP_LIST    8'h30
`define PMG_REG_COUNTS      8'h34
`define PMG_REG_REP_COUNT   8'h38

// Control fields
`define PMG_CTRL_ENABLE     0
`define PMG_CTRL_MODE_LO    1
`define PMG_CTRL_MODE_HI    2
`define PMG_CTRL_DBL_LEGACY 3
`define PMG_CTRL_SRC_EXT    4
`define PMG_CTRL_SLOW_EDGE  5
`define PMG_CTRL_SYNC_OUT   6
`define PMG_CTRL_INVERT     7
`define PMG_CTRL_TRIG_LO    8
`define PMG_CTRL_TRIG_HI    10
`define PMG_CMD_TRIGGER     0
`define PMG_STAT_ERROR      0

// Pulse modes
`define PMG_MODE_SINGLE     2'h0
`define PMG_MODE_DOUBLE     2'h1
`define PMG_MODE_TRAIN      2'h2

// Trigger modes
`define PMG_TRIG_AUTO       3'h0
`define PMG_TRIG_ONCE       3'h1
`define PMG_TRIG_EXT        3'h2
`define PMG_TRIG_EXT_ONCE   3'h3
`define PMG_TRIG_EXT_GATE   3'h4

// Times in ns, the tick and the clock period
`define PMG_TICK_NS         36'h0_0000_0005
`define PMG_CLK_NS          36'h0_0000_0014
`define PMG_TICKS_PER_CLK   (`PMG_CLK_NS / `PMG_TICK_NS)
`define PMG_PERIOD_RST_NS   36'h0_0000_2710
`define PMG_WIDTH_RST_NS    36'h0_0000_07D0
`define PMG_DELAY_RST_NS    36'h0_000F_4240
`define PMG_DBL_DLY_RST_NS  36'h0_0000_03E8
`define PMG_DBL_WID_RST_NS  36'h0_0000_03E8
`define PMG_MIN_NS          36'h0_0000_0014
`define PMG_GAP_NS          36'h0_0000_0014
`define PMG_TIME_MAX_S      36'h0_0000_0064
`define PMG_TICKS_PER_S     36'h0_0BEB_C200
`define PMG_MIN_TICKS       (`PMG_MIN_NS / `PMG_TICK_NS)
`define PMG_GAP_TICKS       (`PMG_GAP_NS / `PMG_TICK_NS)
`define PMG_MAX_TICKS       (`PMG_TIME_MAX_S * `PMG_TICKS_PER_S)

// Train list limits
`define PMG_LIST_DEPTH      11'h7FF
`define PMG_ENTRY_MAX_NS    36'h0_004C_4B40
`define PMG_ENTRY_MAX_TICKS (`PMG_ENTRY_MAX_NS / `PMG_TICK_NS)

`endif

// *** pmg_train_mem.v ***
// Train list storage: high, low and repeat entries appended in order
`timescale 1ns/1ps
`include "pmg_defs.vh"
module pmg_train_mem (
    // Clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // Append and clear
    input wire clear_in,
    input wire wr_high_in,
    input wire wr_low_in,
    input wire wr_rep_in,
    input wire [19:0] time_in,
    input wire [15:0] rep_in,
    // Read side
    input wire [10:0] index_in,
    output wire [19:0] high_out,
    output wire [19:0] low_out,
    output wire [15:0] rep_out,
    output wire [10:0] high_cnt_out,
    output wire [10:0] low_cnt_out,
    output wire [10:0] rep_cnt_out
);
    reg [19:0] high_mem [0:2046];
    reg [19:0] low_mem [0:2046];
    reg [15:0] rep_mem [0:2046];
    reg [10:0] high_cnt_q;
    reg [10:0] low_cnt_q;
    reg [10:0] rep_cnt_q;

    ////////////////////////////////////////////////////////////////////
    // Appends stop at a full list; clear empties the counts only
    always @(posedge sys_clk_in) begin
        if (sys_rst_in || clear_in) begin
            high_cnt_q <= 11'h000;
            low_cnt_q <= 11'h000;
            rep_cnt_q <= 11'h000;
        end else begin
            if (wr_high_in && high_cnt_q != `PMG_LIST_DEPTH) begin
                high_mem[high_cnt_q] <= time_in;
                high_cnt_q <= high_cnt_q + 11'h001;
            end
            if (wr_low_in && low_cnt_q != `PMG_LIST_DEPTH) begin
                low_mem[low_cnt_q] <= time_in;
                low_cnt_q <= low_cnt_q + 11'h001;
            end
            if (wr_rep_in && rep_cnt_q != `PMG_LIST_DEPTH) begin
                rep_mem[rep_cnt_q] <= rep_in;
                rep_cnt_q <= rep_cnt_q + 11'h001;
            end
        end
    end

    // Entries past the count are read by the sequencer only to finish an entry after a clear
    assign high_out = high_mem[index_in];
    assign low_out = low_mem[index_in];
    assign rep_out = rep_mem[index_in];
    assign high_cnt_out = high_cnt_q;
    assign low_cnt_out = low_cnt_q;
    assign rep_cnt_out = rep_cnt_q;
endmodule // pmg_train_mem

// *** pmg_ext_src.sv ***
// External pulse source and trigger line facing the generator
`timescale 1ns/1ps
module pmg_ext_src (
    // Clock and bench control
    input wire sys_clk_in,
    input wire run_in,
    input wire fire_in,
    // Lines into the generator
    output reg pulse_out = 1'b0,
    output reg trig_out = 1'b0
);
    reg [2:0] cnt_q = 3'h0;
    // Eight-cycle halves while running; a stopped source rests in the gap
    always @(posedge sys_clk_in) begin
        cnt_q <= run_in ? cnt_q + 3'h1 : 3'h0;
        pulse_out <= run_in & ((cnt_q == 3'h7) ^ pulse_out);
        trig_out <= fire_in;
    end
endmodule // pmg_ext_src

// *** pmg_top_chk.sv ***
// Port checker for the pulse modulation generator
`timescale 1ns/1ps
`include "pmg_defs.vh"
module pmg_top_chk (
    // Clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_rdata_out,
    // Pins
    input wire ext_pulse_in,
    input wire ext_trig_in,
    input wire rf_gate_out,
    input wire signal_valid_out,
    input wire slow_edge_out
);
    reg [10:0] ctrl_q;
    // Auto-mode internal start from idle; train is left out, it needs a list
    wire start_w = reg_wr_in && reg_addr_in == `PMG_REG_CTRL && !ctrl_q[0]
        && reg_wdata_in[0] && !reg_wdata_in[4] && reg_wdata_in[2:1] != 2'h2
        && reg_wdata_in[10:8] == 3'h0;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Mirror of the control word, to judge outputs against settings
    always @(posedge sys_clk_in) begin
        if (sys_rst_in)
            ctrl_q <= 11'h0;
        else if (reg_wr_in && reg_addr_in == `PMG_REG_CTRL)
            ctrl_q <= reg_wdata_in[10:0];
    end
    a_read_slot_only: assert property (!reg_rd_in |=> reg_rdata_out == 0)
        else $error("read data outside its slot");
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst_in |=> !rf_gate_out && !signal_valid_out && !slow_edge_out)
        else $error("outputs not cleared by reset");
    a_edge_follow: assert property (
        $stable(ctrl_q[5]) |-> slow_edge_out == ctrl_q[5])
        else $error("edge setting output wrong");
    a_sync_off_low: assert property (!ctrl_q[6] && !$past(ctrl_q[6])
        && !$past(ctrl_q[6], 2) |-> !signal_valid_out)
        else $error("valid output driven with sync off");
    a_sync_copy: assert property (
        (ctrl_q[6] && $stable(rf_gate_out)) [*3] |->
        signal_valid_out == rf_gate_out)
        else $error("valid output not a copy of rf gate");
    a_off_no_rf: assert property (!ctrl_q[0] && !$past(ctrl_q[0])
        && !$past(ctrl_q[0], 2) |-> !rf_gate_out)
        else $error("rf gate high while disabled");
    a_auto_start: assert property (start_w |-> ##[2:3] rf_gate_out)
        else $error("auto start missing");
    a_ext_route: assert property ((ctrl_q[0] && ctrl_q[4]
        && $stable(ext_pulse_in) && $stable(ctrl_q[7])) [*4] |->
        rf_gate_out == (ext_pulse_in ^ ctrl_q[7]))
        else $error("external pulse routed wrongly");
endmodule // pmg_top_chk
bind pmg_top pmg_top_chk chk (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .ext_pulse_in(ext_pulse_in), .ext_trig_in(ext_trig_in),
    .rf_gate_out(rf_gate_out), .signal_valid_out(signal_valid_out),
    .slow_edge_out(slow_edge_out));

// *** tb_pulse_modulation_generator.sv ***
// Self-checking bench for the pulse modulation generator
`timescale 1ns/1ps
`include "pmg_defs.vh"
module tb_pulse_modulation_generator;
    reg sys_clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg run = 1'b0, fire = 1'b0;
    wire [31:0] rdata;
    wire ext_p, ext_t, rf, sv, se;
    integer fail_count = 0;
    integer num_checks = 0;
    integer n, i;
    // Clock
    always #10 sys_clk_in = ~sys_clk_in;
    pmg_top dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .ext_pulse_in(ext_p),
        .ext_trig_in(ext_t), .rf_gate_out(rf), .signal_valid_out(sv),
        .slow_edge_out(se));
    pmg_ext_src src (.sys_clk_in(sys_clk_in), .run_in(run),
        .fire_in(fire), .pulse_out(ext_p), .trig_out(ext_t));
    task summarize;
        begin
            if (fail_count == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wreg(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk_in);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge sys_clk_in);
            wr <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rreg(input [7:0] a, input [31:0] e, input [31:0] m = 32'hFFFF_FFFF);
        begin
            @(posedge sys_clk_in);
            addr <= a;
            rd <= 1'b1;
            @(posedge sys_clk_in);
            rd <= 1'b0;
            #1 chk(rdata & m, e);
        end
    endtask
    // Cycles rf keeps one level, bounded against a stuck gate
    task run_len(input val, output integer c);
        begin
            c = 0;
            #1;
            while (rf === val && c < 3000) begin
                @(posedge sys_clk_in);
                #1 c = c + 1;
            end
        end
    endtask
    task seg(input integer eh, input integer el);
        begin
            run_len(1'b1, n);
            chk(n, eh);
            run_len(1'b0, n);
            chk(n, el);
        end
    endtask
    task count(input integer cyc);
        begin
            n = 0;
            repeat (cyc) begin
                @(posedge sys_clk_in);
                #1 n = n + (rf === 1'b1);
            end
        end
    endtask
    task t_reset;
        begin
            rreg(`PMG_REG_CTRL, 32'h0);
            rreg(`PMG_REG_PERIOD_LO, 32'h7D0);
            rreg(`PMG_REG_WIDTH_LO, 32'h190);
            rreg(`PMG_REG_DELAY_LO, 32'h3_0D40);
            rreg(`PMG_REG_DBL_DLY_LO, 32'hC8);
            rreg(`PMG_REG_DBL_WID_LO, 32'hC8);
            rreg(`PMG_REG_COUNTS, 32'h0);
            rreg(`PMG_REG_REP_COUNT, 32'h0);
            rreg(8'h3C, 32'h0);
        end
    endtask
    task t_single;
        begin
            wreg(`PMG_REG_PERIOD_LO, 32'h28);
            wreg(`PMG_REG_WIDTH_LO, 32'hC);
            wreg(`PMG_REG_DELAY_LO, 32'h0);
            wreg(`PMG_REG_CTRL, 32'h1);
            run_len(1'b0, n);
            seg(3, 7);
            wreg(`PMG_REG_WIDTH_LO, 32'h28);
            run_len(1'b1, n);
            run_len(1'b0, n);
            seg(9, 1);
            rreg(`PMG_REG_STATUS, 32'h8, 32'h8);
            wreg(`PMG_REG_CTRL, 32'h0);
        end
    endtask
    task t_double;
        begin
            wreg(`PMG_REG_PERIOD_LO, 32'h50);
            wreg(`PMG_REG_WIDTH_LO, 32'h8);
            wreg(`PMG_REG_DBL_DLY_LO, 32'h28);
            wreg(`PMG_REG_DBL_WID_LO, 32'hC);
            for (i = 0; i < 2; i = i + 1) begin
                wreg(`PMG_REG_CTRL, i ? 32'h3 : 32'h9);
                run_len(1'b0, n);
                seg(2, 8);
                seg(3, 7);
                wreg(`PMG_REG_CTRL, 32'h0);
            end
        end
    endtask
    task t_ext;
        begin
            wreg(`PMG_REG_CTRL, 32'h71);
            run <= 1'b1;
            repeat (40) @(posedge sys_clk_in);
            run <= 1'b0;
            repeat (6) @(posedge sys_clk_in);
            #1 chk(rf, 1'b0);
            chk(sv, 1'b0);
            chk(se, 1'b1);
            wreg(`PMG_REG_CTRL, 32'hF1);
            repeat (6) @(posedge sys_clk_in);
            #1 chk(rf, 1'b1);
            chk(sv, 1'b1);
            wreg(`PMG_REG_CTRL, 32'h0);
        end
    endtask
    task t_train;
        begin
            wreg(`PMG_REG_CTRL, 32'h5);
            rreg(`PMG_REG_STATUS, 32'h1, 32'h1);
            wreg(`PMG_REG_STATUS, 32'h1);
            rreg(`PMG_REG_STATUS, 32'h0, 32'h1);
            wreg(`PMG_REG_CTRL, 32'h0);
            wreg(`PMG_REG_LIST_SEL, 32'h55);
            rreg(`PMG_REG_LIST_SEL, 32'h1_0055);
            for (i = 0; i < 3; i = i + 1) begin
                wreg(`PMG_REG_HIGH_LIST, 32'h8 + 4 * i);
                wreg(`PMG_REG_LOW_LIST, 32'h8);
                wreg(`PMG_REG_REP_LIST, 32'h2 - i);
            end
            rreg(`PMG_REG_COUNTS, 32'h3_0003);
            rreg(`PMG_REG_REP_COUNT, 32'h3);
            wreg(`PMG_REG_CTRL, 32'h5);
            run_len(1'b0, n);
            // Load clocks lengthen gaps: one per pair, skip and wrap
            seg(2, 2);
            seg(2, 3);
            seg(3, 5);
            seg(2, 2);
            wreg(`PMG_REG_CTRL, 32'h0);
            wreg(`PMG_REG_LIST_SEL, 32'h66);
            rreg(`PMG_REG_COUNTS, 32'h0);
        end
    endtask
    task t_trig;
        begin
            for (i = 1; i < 5; i = i + 1) begin
                wreg(`PMG_REG_CTRL, 32'h1 | (i << 8));
                count(30);
                chk(n, 0);
                if (i == 1)
                    wreg(`PMG_REG_CMD, 32'h1);
                else begin
                    @(posedge sys_clk_in);
                    fire <= 1'b1;
                end
                count(60);
                chk(i[0] ? n : n > 0, i[0] ? 2 : 1);
                @(posedge sys_clk_in);
                fire <= 1'b0;
                wreg(`PMG_REG_CTRL, 32'h0);
            end
        end
    endtask
    // Watchdog at 10,000 cycles, far past the tests
    initial begin
        #200_000;
        fail_count = fail_count + 1;
        summarize;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        t_reset;
        t_single;
        t_double;
        t_ext;
        t_train;
        t_trig;
        summarize;
    end
endmodule // tb_pulse_modulation_generator
